// *** hw/hoc_params.svh ***
`ifndef HOC_PARAMS_SVH
`define HOC_PARAMS_SVH
// Sizes
`define HOC_GROUPS 8
`define HOC_HARM_N 13
`define HOC_MAG_W 16
// Timing
`define HOC_CLK_NS 5
`define HOC_MS_NS 1000000
`define HOC_SAMPLE_MS 5
`define HOC_PREF_MS 20
`define HOC_PREF_N (`HOC_PREF_MS / `HOC_SAMPLE_MS)
`define HOC_HIST_N (2 * `HOC_PREF_N)
// Thresholds
`define HOC_RELEASE_PCT 97
`define HOC_PCT_FULL 100
`define HOC_PCT_SCALE 10000
`define HOC_FULL_SCALE 16'hffff
`define HOC_HARM_MAX 4'hc
`define HOC_HARM_DFLT 4'h1
// Register byte offsets
`define HOC_OFS_CTRL 8'h00
`define HOC_OFS_STATUS 8'h04
`define HOC_OFS_CNT_START 8'h08
`define HOC_OFS_CNT_TRIP 8'h0c
`define HOC_OFS_CNT_BLOCK 8'h10
`define HOC_OFS_MEAS 8'h14
`define HOC_OFS_PREFAULT 8'h18
`define HOC_OFS_TIME 8'h1c
`define HOC_OFS_GRP_LO 8'h40
`define HOC_OFS_GRP_HI 8'hbf
`define HOC_GRP_CFG 4'h0
`define HOC_GRP_PICK 4'h4
`define HOC_GRP_DELAY 4'h8
// Field positions
`define HOC_CTRL_GRP_LSB 0
`define HOC_CTRL_CLR_LSB 8
`define HOC_CFG_MODE_LSB 0
`define HOC_CFG_HARM_LSB 4
`define HOC_CFG_PCT_BIT 8
`define HOC_CFG_CHAN_LSB 12
// Reset values: mode, harmonic, percent, channel, pick-up, delay
`define HOC_RST_GROUP {2'h1, 4'h1, 1'h0, 2'h0, 16'h0014, 16'h003c}
`endif

// *** hw/hoc_pkg.sv ***
`include "hoc_params.svh"

package hoc_pkg;
    typedef logic [`HOC_MAG_W-1:0] hoc_mag_type;
    typedef hoc_mag_type [`HOC_HARM_N-1:0] hoc_spectrum_type;
    typedef enum logic [1:0] {
        HOC_NORMAL = 2'h0, HOC_START = 2'h1, HOC_TRIP = 2'h2,
        HOC_BLOCKED = 2'h3
    } hoc_cond_type;
    typedef enum logic [1:0] {
        HOC_INSTANT = 2'h0, HOC_DT = 2'h1, HOC_IDMT = 2'h2
    } hoc_mode_type;
    typedef enum logic [1:0] {
        HOC_CH_PHASE = 2'h0, HOC_CH_RES1 = 2'h1, HOC_CH_RES2 = 2'h2
    } hoc_chan_type;
    typedef struct packed {
        hoc_mode_type mode;
        logic [3:0] harm;
        logic pct;
        hoc_chan_type chan;
        logic [15:0] pick;
        logic [15:0] delay;
    } hoc_group_type;
    // Flags: block off/on, trip off/on, start off/on
    typedef struct packed {
        logic [5:0] flags;
        logic [31:0] stamp;
    } hoc_event_type;
    typedef struct packed {
        hoc_group_type [`HOC_GROUPS-1:0] groups;
        logic [2:0] act;
        logic ap_pend;
        logic ap_write;
        logic [7:0] ap_addr;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
        hoc_mag_type [2:0] harm;
        hoc_mag_type [2:0] fund;
        logic pick;
        logic start;
        logic trip;
        logic blocked;
        hoc_cond_type cond;
        logic [31:0] tmr;
        logic [31:0] div;
        logic [31:0] now;
        logic [31:0] cnt_start;
        logic [31:0] cnt_trip;
        logic [31:0] cnt_block;
        hoc_mag_type [`HOC_HIST_N-1:0] hist;
        hoc_mag_type meas;
        hoc_mag_type pref;
        logic evt_valid;
        hoc_event_type evt;
    } hoc_state_type;
endpackage : hoc_pkg

// *** hw/hoc_stage.sv ***
// Summary of operation
// - Eight setting groups, one selected as active
// - Group and block changes apply while running
// - Instant, definite-time or inverse-time delay modes
// - Select, process, saturate, compare, block, delay, output
// - Three phases share one common pick-up setting
// - Start, trip, blocked outputs with on/off events
// - Instant mode: start and trip events together
// - Event time stamps count whole milliseconds
// - Cumulative clearable start, trip, blocked counters
// - Monitor harmonic per unit or percent of fundamental
// - Settings pick channel, harmonic and monitoring type
// - Pre-fault: 20 ms average ending 20 ms earlier
// - Pick-up above setting, release below 97 percent
// - Blocking at pick-up gives blocked, not start
// - Condition code normal, start, trip, blocked
`include "hoc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module hoc_stage #(
    parameter int unsigned MS_CYCLES = `HOC_MS_NS / `HOC_CLK_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic hreadyout,
    output var logic [31:0] hrdata,
    output var logic hresp,
    input wire logic sample_valid,
    input wire logic block_in,
    input wire hoc_pkg::hoc_spectrum_type phase_a_spectrum,
    input wire hoc_pkg::hoc_spectrum_type phase_b_spectrum,
    input wire hoc_pkg::hoc_spectrum_type phase_c_spectrum,
    input wire hoc_pkg::hoc_spectrum_type residual_one_spectrum,
    input wire hoc_pkg::hoc_spectrum_type residual_two_spectrum,
    output var logic start,
    output var logic trip,
    output var logic blocked,
    output var hoc_pkg::hoc_cond_type condition,
    output var logic evt_valid,
    output var hoc_pkg::hoc_event_type evt_info
);

    hoc_pkg::hoc_state_type s_q;
    hoc_pkg::hoc_state_type s_d;
    hoc_pkg::hoc_group_type grp;
    hoc_pkg::hoc_spectrum_type [2:0] phases;
    hoc_pkg::hoc_mag_type [2:0] lane_harm;
    hoc_pkg::hoc_mag_type [2:0] lane_fund;
    logic [2:0] over;
    logic [2:0] under;
    logic [1:0] lvl [3];
    logic [3:0] hidx;

    // ************************************************************
    // Setting selection and input lanes
    // ************************************************************

    // Active group steers everything below
    assign grp = s_q.groups[s_q.act];
    assign hidx = (grp.harm > `HOC_HARM_MAX) ? `HOC_HARM_DFLT : grp.harm;
    assign phases = {phase_c_spectrum, phase_b_spectrum, phase_a_spectrum};

    genvar i;
    for (i = 0; i < 3; i++) begin : g_lane
        hoc_pkg::hoc_spectrum_type src;
        logic [47:0] num;
        logic [47:0] den;
        logic [47:0] refv;
        logic sat;
        logic ok;

        // Channel choice: three phases or one residual copied
        always_comb begin
            case (grp.chan)
                hoc_pkg::HOC_CH_RES1: src = residual_one_spectrum;
                hoc_pkg::HOC_CH_RES2: src = residual_two_spectrum;
                default: src = phases[i];
            endcase
        end
        assign lane_harm[i] = src[hidx];
        assign lane_fund[i] = src[0];

        // Per unit or percent of fundamental, cross-multiplied
        assign num = grp.pct ?
            48'(s_q.harm[i]) * 48'(`HOC_PCT_SCALE) : 48'(s_q.harm[i]);
        assign den = grp.pct ? 48'(s_q.fund[i]) : 48'h1;
        assign refv = 48'(grp.pick) * den;
        // Saturated inputs count as above the setting, except in percent mode with a zero fundamental
        assign sat = (s_q.harm[i] == `HOC_FULL_SCALE) ||
            (s_q.fund[i] == `HOC_FULL_SCALE);
        assign ok = !(grp.pct && s_q.fund[i] == 16'h0000);
        // Pick-up and 97 percent release, common setting
        assign over[i] = ok && (sat || num > refv);
        assign under[i] = !ok || (!sat && num * 48'(`HOC_PCT_FULL) <
            refv * 48'(`HOC_RELEASE_PCT));
        // Multiple of setting for the inverse-time weight
        assign lvl[i] = (sat || num > (refv << 3)) ? 2'h3 :
            (num > (refv << 2)) ? 2'h2 :
            (num > (refv << 1)) ? 2'h1 : 2'h0;
    end

    // ************************************************************
    // Stage sequence and register slave
    // ************************************************************

    // Whole stage in fixed order each clock
    always_comb begin
        logic tick;
        logic [2:0] clr;
        logic [2:0] gi;
        logic [1:0] lmax;
        logic [31:0] rd;
        logic [17:0] sum;
        hoc_pkg::hoc_mag_type newmax;
        s_d = s_q;
        tick = 1'b0;
        clr = 3'h0;
        gi = 3'(s_q.ap_addr[7:4] - 4'h4);
        lmax = 2'h0;
        rd = 32'h0000_0000;
        sum = 18'h00000;
        newmax = 16'h0000;
        s_d.evt_valid = 1'b0;
        s_d.hresp = 1'b0;

        // Millisecond time base for stamps and delays
        if (s_q.div == 32'(MS_CYCLES - 1)) begin
            s_d.div = 32'h0000_0000;
            s_d.now = s_q.now + 32'h1;
            tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 32'h1;
        end

        // Capture a new spectrum set, 5 ms cadence expected
        for (int k = 0; k < 3; k++) begin
            if (lane_harm[k] > newmax) begin
                newmax = lane_harm[k];
            end
            if (over[k] && lvl[k] > lmax) begin
                lmax = lvl[k];
            end
        end
        if (sample_valid) begin
            s_d.harm = lane_harm;
            s_d.fund = lane_fund;
            s_d.meas = newmax;
            s_d.hist = {s_q.hist[`HOC_HIST_N-2:0], newmax};
        end

        // Threshold with hysteresis
        if (|over) begin
            s_d.pick = 1'b1;
        end else if (&under) begin
            s_d.pick = 1'b0;
        end

        // Block check: blocked instead of start
        s_d.start = s_d.pick & ~block_in;
        s_d.blocked = s_d.pick & block_in;

        // Time delay characteristics
        if (!s_d.start) begin
            s_d.tmr = 32'h0000_0000;
            s_d.trip = 1'b0;
        end else begin
            case (grp.mode)
                hoc_pkg::HOC_INSTANT: begin
                    s_d.trip = 1'b1;
                end
                hoc_pkg::HOC_DT: begin
                    // One extra tick covers a partial first millisecond
                    if (tick && s_q.tmr <= 32'(grp.delay)) begin
                        s_d.tmr = s_q.tmr + 32'h1;
                    end
                    s_d.trip = (s_d.tmr > 32'(grp.delay)) ||
                        (grp.delay == 16'h0000);
                end
                hoc_pkg::HOC_IDMT: begin
                    if (tick && s_q.tmr < 32'(grp.delay)) begin
                        s_d.tmr = s_q.tmr + (32'h1 << lmax);
                    end
                    s_d.trip = s_d.tmr >= 32'(grp.delay);
                end
                default: begin
                    s_d.trip = 1'b0;
                end
            endcase
        end

        // Condition code
        if (s_d.blocked) begin
            s_d.cond = hoc_pkg::HOC_BLOCKED;
        end else if (s_d.trip) begin
            s_d.cond = hoc_pkg::HOC_TRIP;
        end else if (s_d.start) begin
            s_d.cond = hoc_pkg::HOC_START;
        end else begin
            s_d.cond = hoc_pkg::HOC_NORMAL;
        end

        // On/off events sharing one stamp
        s_d.evt.flags = {
            s_q.blocked & ~s_d.blocked, ~s_q.blocked & s_d.blocked,
            s_q.trip & ~s_d.trip, ~s_q.trip & s_d.trip,
            s_q.start & ~s_d.start, ~s_q.start & s_d.start};
        s_d.evt.stamp = s_q.now;
        s_d.evt_valid = |s_d.evt.flags;
        if (!s_d.evt_valid) begin
            s_d.evt = s_q.evt;
        end

        // Pre-fault average of the older half of history
        if (s_d.evt.flags[0] & s_d.evt_valid ||
            s_d.evt.flags[2] & s_d.evt_valid) begin
            for (int k = `HOC_PREF_N; k < `HOC_HIST_N; k++) begin
                sum = sum + 18'(s_q.hist[k]);
            end
            s_d.pref = 16'(sum / 18'(`HOC_PREF_N));
        end

        // Bus data phase: one wait state, then data
        if (s_q.ap_pend) begin
            s_d.ap_pend = 1'b0;
            s_d.hready = 1'b1;
            if (s_q.ap_write) begin
                case (s_q.ap_addr)
                    `HOC_OFS_CTRL: begin
                        s_d.act = hwdata[`HOC_CTRL_GRP_LSB +: 3];
                        clr = hwdata[`HOC_CTRL_CLR_LSB +: 3];
                    end
                    default: begin
                        if (s_q.ap_addr >= `HOC_OFS_GRP_LO &&
                            s_q.ap_addr <= `HOC_OFS_GRP_HI) begin
                            case (s_q.ap_addr[3:0])
                                `HOC_GRP_CFG: begin
                                    s_d.groups[gi].mode =
                                        hoc_pkg::hoc_mode_type'(
                                        hwdata[`HOC_CFG_MODE_LSB +: 2]);
                                    s_d.groups[gi].harm =
                                        hwdata[`HOC_CFG_HARM_LSB +: 4];
                                    s_d.groups[gi].pct =
                                        hwdata[`HOC_CFG_PCT_BIT];
                                    s_d.groups[gi].chan =
                                        hoc_pkg::hoc_chan_type'(
                                        hwdata[`HOC_CFG_CHAN_LSB +: 2]);
                                end
                                `HOC_GRP_PICK: begin
                                    s_d.groups[gi].pick = hwdata[15:0];
                                end
                                `HOC_GRP_DELAY: begin
                                    s_d.groups[gi].delay = hwdata[15:0];
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                endcase
            end else begin
                case (s_q.ap_addr)
                    `HOC_OFS_CTRL: rd[`HOC_CTRL_GRP_LSB +: 3] = s_q.act;
                    `HOC_OFS_STATUS: rd = {26'h0, s_q.pick, s_q.blocked,
                        s_q.trip, s_q.start, s_q.cond};
                    `HOC_OFS_CNT_START: rd = s_q.cnt_start;
                    `HOC_OFS_CNT_TRIP: rd = s_q.cnt_trip;
                    `HOC_OFS_CNT_BLOCK: rd = s_q.cnt_block;
                    `HOC_OFS_MEAS: rd = {16'h0, s_q.meas};
                    `HOC_OFS_PREFAULT: rd = {16'h0, s_q.pref};
                    `HOC_OFS_TIME: rd = s_q.now;
                    default: begin
                        if (s_q.ap_addr >= `HOC_OFS_GRP_LO &&
                            s_q.ap_addr <= `HOC_OFS_GRP_HI) begin
                            case (s_q.ap_addr[3:0])
                                `HOC_GRP_CFG: begin
                                    rd[`HOC_CFG_MODE_LSB +: 2] =
                                        s_q.groups[gi].mode;
                                    rd[`HOC_CFG_HARM_LSB +: 4] =
                                        s_q.groups[gi].harm;
                                    rd[`HOC_CFG_PCT_BIT] =
                                        s_q.groups[gi].pct;
                                    rd[`HOC_CFG_CHAN_LSB +: 2] =
                                        s_q.groups[gi].chan;
                                end
                                `HOC_GRP_PICK:
                                    rd[15:0] = s_q.groups[gi].pick;
                                `HOC_GRP_DELAY:
                                    rd[15:0] = s_q.groups[gi].delay;
                                default: rd = 32'h0000_0000;
                            endcase
                        end
                    end
                endcase
                s_d.hrdata = rd;
            end
        end else if (hsel && hready && htrans[1]) begin
            // Address phase taken
            s_d.ap_pend = 1'b1;
            s_d.ap_write = hwrite;
            s_d.ap_addr = haddr[7:0];
            s_d.hready = 1'b0;
        end

        // Counters: a new event wins over a clear
        s_d.cnt_start = (clr[0] ? 32'h0 : s_q.cnt_start) +
            32'(s_d.evt.flags[0] & s_d.evt_valid);
        s_d.cnt_trip = (clr[1] ? 32'h0 : s_q.cnt_trip) +
            32'(s_d.evt.flags[2] & s_d.evt_valid);
        s_d.cnt_block = (clr[2] ? 32'h0 : s_q.cnt_block) +
            32'(s_d.evt.flags[4] & s_d.evt_valid);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.hready <= 1'b1;
            for (int g = 0; g < `HOC_GROUPS; g++) begin
                s_q.groups[g] <= `HOC_RST_GROUP;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Every output straight from the state register
    assign hreadyout = s_q.hready;
    assign hrdata = s_q.hrdata;
    assign hresp = s_q.hresp;
    assign start = s_q.start;
    assign trip = s_q.trip;
    assign blocked = s_q.blocked;
    assign condition = s_q.cond;
    assign evt_valid = s_q.evt_valid;
    assign evt_info = s_q.evt;

endmodule : hoc_stage
`default_nettype wire

// *** testbench/hoc_stage_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Stage checker on the top module's ports
// ****************************************
module hoc_stage_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic sample_valid,
    input wire logic start,
    input wire logic trip,
    input wire logic blocked,
    input wire hoc_pkg::hoc_cond_type condition,
    input wire logic evt_valid,
    input wire hoc_pkg::hoc_event_type evt_info
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Bus request, then one wait state
    sequence bus_req;
        hsel && hready && htrans[1];
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_bus_wait: assert property (bus_req |=> one_wait)
        else $error("bus wait state wrong");
    a_cond_code: assert property (condition == (blocked ? 2'h3 : trip ? 2'h2 :
        start ? 2'h1 : 2'h0))
        else $error("condition code mismatch");
    a_block_excl: assert property (blocked |-> !start && !trip)
        else $error("blocked with start or trip");
    a_trip_start: assert property (trip |-> start)
        else $error("trip without start");
    a_start_on: assert property ($rose(start) |-> evt_valid && evt_info.flags[0])
        else $error("no start on event");
    a_start_off: assert property ($fell(start) |-> evt_valid && evt_info.flags[1])
        else $error("no start off event");
    a_trip_on: assert property ($rose(trip) |-> evt_valid && evt_info.flags[2])
        else $error("no trip on event");
    a_block_on: assert property ($rose(blocked) |-> evt_valid && evt_info.flags[4])
        else $error("no block on event");
    a_start_lat: assert property ($rose(start) |-> $past(sample_valid, 2))
        else $error("start not two edges after sample");
    a_instant_pair: assert property ($rose(start) && $rose(trip)
        |-> evt_info.flags[2:0] == 3'h5)
        else $error("start and trip not in one event");
endmodule : hoc_stage_chk

bind hoc_stage hoc_stage_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
    .sample_valid(sample_valid), .start(start), .trip(trip),
    .blocked(blocked), .condition(condition), .evt_valid(evt_valid),
    .evt_info(evt_info));

`default_nettype wire

// *** testbench/hoc_front.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Measurement front end model
// ****************************************
module hoc_front #(
    parameter int unsigned PERIOD = 100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] lane,
    input wire hoc_pkg::hoc_mag_type mag,
    output var logic sample_valid,
    output var hoc_pkg::hoc_spectrum_type spec_a,
    output var hoc_pkg::hoc_spectrum_type spec_b,
    output var hoc_pkg::hoc_spectrum_type spec_c,
    output var hoc_pkg::hoc_spectrum_type spec_r1,
    output var hoc_pkg::hoc_spectrum_type spec_r2
);
    int unsigned cnt_q;
    hoc_pkg::hoc_spectrum_type val [5];

    // Sample strobe once per 5 ms period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
        end
    end
    assign sample_valid = hresetn && (cnt_q == PERIOD - 1);

    // Five lanes: 1.00 In fundamental, 2nd harmonic on one lane
    always_comb begin
        for (int l = 0; l < 5; l++) begin
            val[l] = '0;
            val[l][0] = 16'h0064;
            if (lane == l) begin
                val[l][1] = mag;
            end
            if (!sample_valid) begin
                val[l] = ~val[l]; // Stale outside the strobe
            end
        end
    end
    assign spec_a = val[0];
    assign spec_b = val[1];
    assign spec_c = val[2];
    assign spec_r1 = val[3];
    assign spec_r2 = val[4];
endmodule : hoc_front

`default_nettype wire

// *** testbench/tb_harmonic_overcurrent_stage.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Register-level test of the stage
// ****************************************
module tb_harmonic_overcurrent_stage;
    localparam int unsigned MS = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic block_in = 1'b0;
    logic [2:0] lane = 3'h0;
    hoc_pkg::hoc_mag_type mag = 16'h0000;
    logic hreadyout, hresp, sample_valid, start, trip, blocked, evt_valid;
    logic [31:0] hrdata, r1, r2;
    hoc_pkg::hoc_spectrum_type sa, sb, sc, s1, s2;
    hoc_pkg::hoc_cond_type condition;
    hoc_pkg::hoc_event_type evt_info;
    int miscompares = 0;
    int n_compared = 0;
    int n_cyc;
    logic [31:0] cnt_exp [3] = '{32'h2, 32'h2, 32'h1};

    // Clock of 5 ns
    always #2.5 hclk = ~hclk;

    hoc_stage #(.MS_CYCLES(MS)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .sample_valid(sample_valid), .block_in(block_in),
        .phase_a_spectrum(sa), .phase_b_spectrum(sb), .phase_c_spectrum(sc),
        .residual_one_spectrum(s1), .residual_two_spectrum(s2),
        .start(start), .trip(trip), .blocked(blocked),
        .condition(condition), .evt_valid(evt_valid), .evt_info(evt_info));

    hoc_front #(.PERIOD(5 * MS)) u_front (.hclk(hclk), .hresetn(hresetn),
        .lane(lane), .mag(mag), .sample_valid(sample_valid), .spec_a(sa),
        .spec_b(sb), .spec_c(sc), .spec_r1(s1), .spec_r2(s2));

    task automatic print_verdict();
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    // One single AHB-Lite transfer, waits on hready
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        hsel <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask : rd_chk

    task automatic drive(input logic [2:0] l, input logic [15:0] m,
        input logic b);
        @(posedge hclk);
        lane <= l;
        mag <= m;
        block_in <= b;
    endtask : drive

    // Bounded wait for a condition code
    task automatic wait_cond(input hoc_pkg::hoc_cond_type c, input int lim);
        n_cyc = 0;
        while (condition !== c && n_cyc < lim) begin
            @(posedge hclk);
            n_cyc++;
        end
        chk({30'h0, condition}, {30'h0, c});
    endtask : wait_cond

    // Watchdog
    initial begin
        #200us;
        miscompares++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h40, 32'h11);
        rd_chk(8'h44, 32'h14);
        rd_chk(8'h48, 32'h3c);
        rd_chk(8'h30, 32'h0);
        // Definite time of 10 ms, fault on phase b only
        wr(8'h48, 32'ha);
        drive(3'h1, 16'h001e, 1'b0);
        wait_cond(hoc_pkg::HOC_START, 400);
        chk({26'h0, evt_info.flags}, 32'h1);
        wait_cond(hoc_pkg::HOC_TRIP, 400);
        chk({31'h0, n_cyc >= 10 * MS && n_cyc <= 11 * MS + 2}, 32'h1);
        chk({26'h0, evt_info.flags}, 32'h4);
        // Release ratio: 20 holds, 19 releases
        drive(3'h1, 16'h0014, 1'b0);
        repeat (15 * MS) @(posedge hclk);
        chk({30'h0, condition}, {30'h0, hoc_pkg::HOC_TRIP});
        drive(3'h1, 16'h0013, 1'b0);
        wait_cond(hoc_pkg::HOC_NORMAL, 400);
        // Instant mode in group 1, chosen while running
        wr(8'h50, 32'h10);
        wr(8'h54, 32'h14);
        wr(8'h00, 32'h1);
        rd_chk(8'h00, 32'h1);
        drive(3'h2, 16'h001e, 1'b0);
        wait_cond(hoc_pkg::HOC_TRIP, 300);
        chk({26'h0, evt_info.flags}, 32'h5);
        drive(3'h2, 16'h0000, 1'b0);
        wait_cond(hoc_pkg::HOC_NORMAL, 300);
        // Blocking present at pick-up
        drive(3'h2, 16'h001e, 1'b1);
        wait_cond(hoc_pkg::HOC_BLOCKED, 300);
        chk({26'h0, evt_info.flags}, 32'h10);
        drive(3'h2, 16'h0000, 1'b1);
        wait_cond(hoc_pkg::HOC_NORMAL, 300);
        // Counters, then clear all three
        for (int k = 0; k < 3; k++) begin
            rd_chk(8'h08 + 8'(4 * k), cnt_exp[k]);
        end
        wr(8'h00, 32'h701);
        for (int k = 0; k < 3; k++) begin
            rd_chk(8'h08 + 8'(4 * k), 32'h0);
        end
        // Percent mode on residual one, 20 % pick-up
        wr(8'h60, 32'h1110);
        wr(8'h64, 32'h7d0);
        wr(8'h00, 32'h2);
        drive(3'h0, 16'h005a, 1'b0);
        repeat (15 * MS) @(posedge hclk);
        chk({30'h0, condition}, {30'h0, hoc_pkg::HOC_NORMAL});
        drive(3'h3, 16'h001e, 1'b0);
        wait_cond(hoc_pkg::HOC_TRIP, 300);
        rd_chk(8'h14, 32'h1e);
        // Millisecond counter over 10 ms
        xfer(1'b0, 8'h1c, 32'h0, r1);
        repeat (10 * MS - 4) @(posedge hclk);
        xfer(1'b0, 8'h1c, 32'h0, r2);
        chk({31'h0, (r2 - r1 == 10) || (r2 - r1 == 11)}, 32'h1);
        print_verdict();
    end
endmodule : tb_harmonic_overcurrent_stage

`default_nettype wire
